//--- core/mot_timer.sv
// Modulo timer: 8-bit counter, clock select, prescaler, overflow flag and registers
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - Gate bit cleared by reset, unclocks block
// - Eight-bit up-counter, free or modulo limited
// - Source: bus, fixed clock, pin edges
// - Prescale ratios one through 256
// - Keeps counting in wait mode
// - Inactive in every stop mode
// - Deep stop wake restores reset state
// - Light stop interrupt exit keeps state
// - Debug mode suspends counting, resumes later
// - External pin synchronised before edge detect
// - Exactly four eight-bit registers
// - Bit 7 read-only overflow flag
// - Flag clears by read then zero write
// - Counter clear or modulo write clears flag
// - Bit 6 interrupt enable gates request
// - Bit 5 write-only counter clear
// - Bit 4 halt, set by reset
// - Bits 3 to 0 read zero
// - Source codes; change keeps count
// - Codes above 1000 act as 256
// - Match rolls to zero, sets flag
// - Count read-only, reset to zero
module mot_timer import mot_pkg::*; #(
    parameter int DIV_BITS = 8           // Prescaler stages
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       clockGate,   // peripheral_clock_gate_reg bit
    input  wire logic       fixedTick,   // fixed_freq_clock one-cycle edge
    input  wire logic       extClockIn,  // ext_timer_clock_in pin
    input  wire logic       stopMode,    // Any stop mode active
    input  wire logic       deepStopWake, // Wake from deep_stop_mode pulse
    input  wire logic       debugActive, // Background debug active
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            irq
);
    mot_req_s   req;             // Bundled register request
    logic [7:0] count;           // current_count_value
    logic [7:0] moduloValue;     // modulo_limit_value
    logic       overflowFlag;    // Overflow status
    logic       irqEnable;       // Interrupt enable
    logic       counterHalt;     // Halt control
    logic [1:0] clockSourceSelect;
    logic [3:0] prescaleSelect;
    logic       flagArmed;       // Status read seen with flag set
    logic       extSync1;        // First synchroniser stage
    logic       extSync2;        // Second synchroniser stage
    logic       extPrev;         // Edge detector history
    logic       srcTick;         // Selected source event
    logic       cntTick;         // Prescaled counter event
    logic       running;         // Counter allowed to advance
    logic       localRst;        // Reset or deep stop wake
    logic       clearReq;        // Counter clear write
    logic       modWrite;        // Modulo write
    logic       rollover;        // Wrap this cycle
    logic       flagZeroWrite;   // Write of zero to the flag bit
    logic       gatedWr;         // Write seen only when clocked
    logic       gatedRd;         // Read seen only when clocked

    // One compare for the clear, modulo write and flag zero write decodes; the read and control cases compare addr directly
    // Takes the bundled request to keep address and strobes together
    function automatic logic hitReg(input mot_req_s r, input logic [1:0] a);
        hitReg = (r.addr == a);
    endfunction : hitReg

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Block answers only while its clock gate is open
    assign gatedWr  = req.wr && clockGate;
    assign gatedRd  = req.rd && clockGate;
    // Deep stop wake resets the timer state; synchroniser, edge history and read data follow srst only
    assign localRst = srst || deepStopWake;
    assign clearReq = gatedWr && hitReg(req, ADDR_STATUS_CONTROL) && req.wdata[BIT_CLEAR];
    assign modWrite = gatedWr && hitReg(req, ADDR_MODULO_VALUE);
    assign flagZeroWrite = gatedWr && hitReg(req, ADDR_STATUS_CONTROL) && !req.wdata[BIT_FLAG];

    // Stop only freezes and keeps every register, so a light stop left by interrupt resumes
    // Running needs gate open, not halted, not in stop or debug
    assign running = clockGate && !counterHalt && !stopMode && !debugActive;

    // Two-flop synchroniser for the pin
    always_ff @(posedge clk) begin
        if (srst) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
        end else begin
            extSync1 <= extClockIn;
            extSync2 <= extSync1;
        end
    end

    // Edge history taken from the second stage only
    always_ff @(posedge clk) begin
        if (srst) begin
            extPrev <= 1'b0;
        end else begin
            extPrev <= extSync2;
        end
    end

    // Source selection
    always_comb begin
        case (mot_src_e'(clockSourceSelect))
            MOT_SRC_BUS:  srcTick = 1'b1;
            MOT_SRC_FIX:  srcTick = fixedTick;
            MOT_SRC_FALL: srcTick = extPrev && !extSync2;
            MOT_SRC_RISE: srcTick = !extPrev && extSync2;
            default:      srcTick = 1'b1;
        endcase
    end

    // Prescaler divides the selected source
    mot_prescaler #(
        .DIV_BITS       (DIV_BITS)
    ) u_prescaler (
        .clk            (clk),
        .srst           (localRst),
        .run            (running),
        .srcTick        (srcTick),
        .prescaleSelect (prescaleSelect),
        .tick           (cntTick)
    );

    // Wrap when count meets a nonzero modulo or reaches the top
    assign rollover = cntTick && (((moduloValue != RST_MODULO) && (count == moduloValue)) ||
                                  (count == 8'hff));

    // Counter; clears win over ticks, writes to count ignored
    always_ff @(posedge clk) begin
        if (localRst) begin
            count <= RST_COUNT;
        end else if (clearReq || modWrite) begin
            count <= RST_COUNT;
        end else if (rollover) begin
            count <= RST_COUNT;
        end else if (cntTick) begin
            count <= count + 8'h01;
        end
    end

    // Control fields; source and prescale changes leave count alone
    always_ff @(posedge clk) begin
        if (localRst) begin
            irqEnable         <= 1'b0;
            counterHalt       <= 1'b1;
            clockSourceSelect <= MOT_SRC_BUS;
            prescaleSelect    <= RST_PS;
            moduloValue       <= RST_MODULO;
        end else if (gatedWr) begin
            case (req.addr)
                ADDR_STATUS_CONTROL: begin
                    irqEnable   <= req.wdata[BIT_IRQEN];
                    counterHalt <= req.wdata[BIT_HALT];
                end
                ADDR_CLOCK_CONFIG: begin
                    clockSourceSelect <= req.wdata[CLOCK_SOURCE_SELECT_LSB +: 2];
                    prescaleSelect    <= req.wdata[PS_LSB +: 4];
                end
                ADDR_MODULO_VALUE: begin
                    moduloValue <= req.wdata;
                end
                default: begin
                    // Count register is read-only
                end
            endcase
        end
    end

    // Arm the clear when status read sees the flag; a new wrap disarms
    always_ff @(posedge clk) begin
        if (localRst) begin
            flagArmed <= 1'b0;
        end else if (rollover) begin
            flagArmed <= 1'b0;
        end else if (gatedRd && (req.addr == ADDR_STATUS_CONTROL) && overflowFlag) begin
            flagArmed <= 1'b1;
        end else if (gatedWr && (req.addr == ADDR_STATUS_CONTROL)) begin
            flagArmed <= 1'b0;
        end
    end

    // Overflow flag: set wins over every clear
    always_ff @(posedge clk) begin
        if (localRst) begin
            overflowFlag <= 1'b0;
        end else if (rollover) begin
            overflowFlag <= 1'b1;
        end else if (clearReq || modWrite) begin
            overflowFlag <= 1'b0;
        end else if (flagZeroWrite && flagArmed) begin
            overflowFlag <= 1'b0;
        end
    end

    // Interrupt level follows flag and enable, also in wait mode
    assign irq = overflowFlag && irqEnable;

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (gatedRd) begin
            case (req.addr)
                ADDR_STATUS_CONTROL: rdata <= {overflowFlag, irqEnable, 1'b0, counterHalt, 4'h0};
                ADDR_CLOCK_CONFIG:   rdata <= {2'h0, clockSourceSelect, prescaleSelect};
                ADDR_COUNT_VALUE:    rdata <= count;
                ADDR_MODULO_VALUE:   rdata <= moduloValue;
                default:             rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Flag sets exactly on wrap and wrap lands on zero
    chk_wrap_sets_flag: assert property (@(posedge clk) disable iff (localRst)
        rollover && !clearReq && !modWrite |=> overflowFlag && (count == RST_COUNT))
        else $error("wrap did not set flag or zero count");

    chk_clear_kills_flag: assert property (@(posedge clk) disable iff (localRst)
        (clearReq || modWrite) && !rollover |=> !overflowFlag && (count == RST_COUNT))
        else $error("clear or modulo write left flag or count");

    chk_halt_freezes: assert property (@(posedge clk) disable iff (localRst)
        counterHalt && !clearReq && !modWrite |=> $stable(count))
        else $error("count moved while halted");

    chk_stop_freezes: assert property (@(posedge clk) disable iff (localRst)
        (stopMode || debugActive) && !clearReq && !modWrite |=> $stable(count))
        else $error("count moved in stop or debug");

    chk_irq_follows: assert property (@(posedge clk) disable iff (localRst)
        rollover && irqEnable && !(gatedWr && hitReg(req, ADDR_STATUS_CONTROL)) |=> irq)
        else $error("wrap with enable set raised no interrupt");

    chk_no_lone_clear: assert property (@(posedge clk) disable iff (localRst)
        overflowFlag && !flagArmed && !clearReq && !modWrite |=> overflowFlag)
        else $error("flag cleared without prior read");

    chk_status_reads: assert property (@(posedge clk) disable iff (srst)
        gatedRd && (req.addr == ADDR_STATUS_CONTROL) |=> (rdata[3:0] == 4'h0) && !rdata[BIT_CLEAR])
        else $error("unused status bits read nonzero");

    chk_modulo_limit: assert property (@(posedge clk) disable iff (localRst)
        (moduloValue != RST_MODULO) && (count <= moduloValue) && !modWrite |=> count <= moduloValue)
        else $error("count passed modulo value");

    chk_gate_blocks: assert property (@(posedge clk) disable iff (localRst)
        !clockGate |=> $stable(count))
        else $error("count moved with gate closed");

    // Every counted tick short of a wrap moves the count by exactly one
    chk_count_steps: assert property (@(posedge clk) disable iff (localRst)
        cntTick && !rollover && !clearReq && !modWrite |=> count == $past(count) + 8'h01)
        else $error("count did not step by one on a tick");

    // Without a tick or a clear the count holds
    chk_idle_holds: assert property (@(posedge clk) disable iff (localRst)
        !cntTick && !clearReq && !modWrite |=> $stable(count))
        else $error("count moved without a tick");

    // Modulo of zero runs through the top value
    chk_free_wrap: assert property (@(posedge clk) disable iff (localRst)
        cntTick && (moduloValue == RST_MODULO) && (count == 8'hff) && !clearReq && !modWrite
        |=> (count == RST_COUNT) && overflowFlag)
        else $error("free run did not wrap at the top");

    // Read data is zero outside the answer cycle
    chk_rdata_idle: assert property (@(posedge clk) disable iff (srst)
        !gatedRd |=> rdata == 8'h00)
        else $error("read data nonzero without a read");

    // Count reads return the value at the strobe
    chk_count_reads: assert property (@(posedge clk) disable iff (srst)
        gatedRd && hitReg(req, ADDR_COUNT_VALUE) |=> rdata == $past(count))
        else $error("count read returned a wrong value");

    // Clock register reads: top bits zero, fields in place
    chk_clock_reads: assert property (@(posedge clk) disable iff (srst)
        gatedRd && hitReg(req, ADDR_CLOCK_CONFIG) |=>
        rdata == {2'h0, $past(clockSourceSelect), $past(prescaleSelect)})
        else $error("clock register read wrong");

    // Closed gate leaves modulo value, interrupt enable and halt alone
    chk_gate_no_write: assert property (@(posedge clk) disable iff (localRst)
        !clockGate |=> $stable(moduloValue) && $stable(irqEnable) && $stable(counterHalt))
        else $error("control changed with gate closed");

    // Modulo write loads the written value
    chk_mod_loads: assert property (@(posedge clk) disable iff (localRst)
        modWrite |=> moduloValue == $past(wdata))
        else $error("modulo write did not load");

    // Any reset or deep stop wake returns the timer to its reset state
    chk_reset_values: assert property (@(posedge clk)
        localRst |=> counterHalt && !irqEnable && !overflowFlag && (count == RST_COUNT) &&
        (moduloValue == RST_MODULO))
        else $error("timer state not at reset values");

    // A rising pin edge is counted only after both synchroniser stages
    chk_sync_depth: assert property (@(posedge clk) disable iff (srst)
        (clockSourceSelect == MOT_SRC_RISE) && srcTick |-> $past(extSync1) && !$past(extSync2))
        else $error("pin edge counted before synchronising");

    // Arming needs a status read
    chk_arm_needs_read: assert property (@(posedge clk) disable iff (localRst)
        !flagArmed && !(gatedRd && hitReg(req, ADDR_STATUS_CONTROL)) |=> !flagArmed)
        else $error("clear armed without a status read");

    // Armed zero write clears the flag unless a wrap lands
    chk_two_step: assert property (@(posedge clk) disable iff (localRst)
        flagArmed && flagZeroWrite && !rollover |=> !overflowFlag)
        else $error("armed zero write left the flag set");

    // Divide by one passes every enabled source event
    chk_div_one: assert property (@(posedge clk) disable iff (localRst)
        (prescaleSelect == RST_PS) |-> (cntTick == (running && srcTick)))
        else $error("divide by one dropped a tick");

    // Clock field writes never touch the count
    chk_src_keeps: assert property (@(posedge clk) disable iff (localRst)
        gatedWr && hitReg(req, ADDR_CLOCK_CONFIG) && !cntTick |=> $stable(count))
        else $error("clock write changed the count");

    // No wrap in stop, so no new flag is set in stop; a flag set before stop still drives irq
    chk_stop_no_wrap: assert property (@(posedge clk) disable iff (localRst)
        stopMode |-> !rollover)
        else $error("wrap while in stop mode");

    // Debug suspends counting, so no wrap either
    chk_debug_no_wrap: assert property (@(posedge clk) disable iff (localRst)
        debugActive |-> !rollover)
        else $error("wrap while in debug");

    // Main scenarios reached by the bench
    cov_rollover: cover property (@(posedge clk) rollover && (moduloValue != RST_MODULO));
    cov_free_wrap: cover property (@(posedge clk) rollover && (moduloValue == RST_MODULO));
    cov_two_step: cover property (@(posedge clk) flagArmed && flagZeroWrite);
    cov_ext_edge: cover property (@(posedge clk) cntTick && clockSourceSelect[1]);
    cov_stop_wake: cover property (@(posedge clk) deepStopWake && (moduloValue != RST_MODULO));
endmodule : mot_timer

//--- core/mot_pkg.sv
// Package holding register map, field layout and reset values of the modulo timer
package mot_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0; // overflow_status_control
    localparam logic [1:0] ADDR_CLOCK_CONFIG   = 2'h1; // clock_source_config
    localparam logic [1:0] ADDR_COUNT_VALUE    = 2'h2; // current_count_value
    localparam logic [1:0] ADDR_MODULO_VALUE   = 2'h3; // modulo_limit_value
    // Status and control bit positions
    localparam int BIT_FLAG  = 7;
    localparam int BIT_IRQEN = 6;
    localparam int BIT_CLEAR = 5;
    localparam int BIT_HALT  = 4;
    // Clock register field positions
    localparam int CLOCK_SOURCE_SELECT_LSB = 4;
    localparam int PS_LSB   = 0;
    // Reset values and the largest prescale code
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_MODULO  = 8'h00;
    localparam logic [3:0] RST_PS      = 4'h0;
    localparam logic [3:0] PS_MAX_CODE = 4'h8; // Divide by 256
    // Clock source encodings
    typedef enum logic [1:0] {
        MOT_SRC_BUS  = 2'h0,
        MOT_SRC_FIX  = 2'h1,
        MOT_SRC_FALL = 2'h2,
        MOT_SRC_RISE = 2'h3
    } mot_src_e;
    // Register port request bundle
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mot_req_s;
endpackage : mot_pkg

//--- core/mot_prescaler.sv
// Prescaler that divides source ticks by a power of two
`timescale 1ns/1ps
module mot_prescaler import mot_pkg::*; #(
    parameter int DIV_BITS = 8             // Prescaler stages
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       run,           // Advance allowed
    input  wire logic       srcTick,       // One-cycle source event
    input  wire logic [3:0] prescaleSelect, // Ratio code
    output logic            tick           // One-cycle output event
);
    logic [DIV_BITS-1:0] divCount; // Free divider chain

    // Saturate unused codes to the largest ratio
    function automatic logic [3:0] clampCode(input logic [3:0] c);
        clampCode = (c > PS_MAX_CODE) ? PS_MAX_CODE : c;
    endfunction : clampCode

    // Divider advances only on counted source edges; held while halted
    always_ff @(posedge clk) begin
        if (srst) begin
            divCount <= '0;
        end else if (run && srcTick) begin
            divCount <= divCount + 1'b1;
        end
    end

    // Tick when all low bits selected by the code are ones
    always_comb begin
        logic [DIV_BITS-1:0] mask;
        mask = '0;
        for (int i = 0; i < DIV_BITS; i++) begin
            if (i < int'(clampCode(prescaleSelect))) begin
                mask[i] = 1'b1;
            end
        end
        tick = run && srcTick && ((divCount & mask) == mask);
    end
endmodule : mot_prescaler

//--- verification/mot_timer_tb.sv
// Self-checking testbench for the modulo timer
`timescale 1ns/1ps
module tb import mot_pkg::*;;
    logic       clk;          // 20 MHz bench clock
    logic       srst;         // Synchronous reset
    logic       clockGate;    // Peripheral gate bit
    logic       fixedTick;    // Fixed clock edge pulse
    logic       extClockIn;   // External pin
    logic       stopMode;     // Stop mode level
    logic       deepStopWake; // Deep stop wake pulse
    logic       debugActive;  // Debug mode level
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    int         failCount;    // Mismatches seen
    int         testsRun;     // Comparisons made
    logic [7:0] got;          // Last read value
    logic [8:0] exp;          // Model result: wrap flag and count
    int         code;
    int         k;
    logic [7:0] modv;

    mot_timer DUT (.clk(clk), .srst(srst), .clockGate(clockGate), .fixedTick(fixedTick),
        .extClockIn(extClockIn), .stopMode(stopMode), .deepStopWake(deepStopWake),
        .debugActive(debugActive), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));

    // Free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        testsRun++;
        if (seen !== want) begin
            failCount++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    // One-cycle write strobe
    task automatic writeReg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : writeReg

    // Read data stands only in the cycle after the strobe
    task automatic readReg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : readReg

    // Fixed-clock events, two cycles apart; prescaler phase cancels for whole multiples
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            fixedTick <= 1'b1;
            @(posedge clk);
            fixedTick <= 1'b0;
        end
    endtask : pulses

    // Counter model from a cleared count: returns wrap flag and count
    function automatic logic [8:0] modelRun(input logic [7:0] m, input int ticks);
        logic [7:0] c;
        logic       w;
        c = 8'h00;
        w = 1'b0;
        for (int i = 0; i < ticks; i++) begin
            if ((c == m && m != 8'h00) || c == 8'hff) begin
                c = 8'h00;
                w = 1'b1;
            end else begin
                c = c + 8'h01;
            end
        end
        return {w, c};
    endfunction : modelRun

    task automatic giveVerdict;
        if (failCount == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : giveVerdict

    // Watchdog: the whole sequence needs well under 60000 cycles
    initial begin
        #3000000;
        failCount++;
        giveVerdict();
    end

    // Main sequence
    initial begin
        {clockGate, fixedTick, extClockIn, stopMode, deepStopWake, debugActive, wr, rd} = 8'h00;
        srst = 1'b1;
        addr = 2'h0;
        wdata = 8'h00;
        failCount = 0;
        testsRun = 0;
        void'($urandom(53903));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h00);
        @(posedge clk);
        clockGate <= 1'b1;
        // Reset values of all four registers
        for (int a = 0; a < 4; a++) begin
            readReg(a[1:0], got);
            check(got, (a == 0) ? 8'h10 : 8'h00);
        end
        writeReg(ADDR_COUNT_VALUE, 8'h5a);
        readReg(ADDR_COUNT_VALUE, got);
        check(got, 8'h00);
        writeReg(ADDR_CLOCK_CONFIG, 8'hff);
        readReg(ADDR_CLOCK_CONFIG, got);
        check(got, 8'h3f);
        writeReg(ADDR_STATUS_CONTROL, 8'hff);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h50);
        // Random prescale codes and small modulo values on the fixed clock
        for (int it = 0; it < 14; it++) begin
            code = (it < 2) ? 15 - it * 7 : $urandom % 16;
            k = 1 + $urandom % 3;
            modv = 8'($urandom % 3);
            writeReg(ADDR_CLOCK_CONFIG, 8'h10 | 8'(code));
            writeReg(ADDR_MODULO_VALUE, modv);
            writeReg(ADDR_STATUS_CONTROL, 8'h00);
            pulses(k << ((code > 8) ? 8 : code));
            writeReg(ADDR_STATUS_CONTROL, 8'h10);
            exp = modelRun(modv, k);
            readReg(ADDR_COUNT_VALUE, got);
            check(got, exp[7:0]);
            readReg(ADDR_STATUS_CONTROL, got);
            check(got, {exp[8], 7'h10});
        end
        // Flag survives a zero write that was not armed by a read
        writeReg(ADDR_MODULO_VALUE, 8'h01);
        writeReg(ADDR_CLOCK_CONFIG, 8'h10);
        writeReg(ADDR_STATUS_CONTROL, 8'h00);
        pulses(2);
        writeReg(ADDR_STATUS_CONTROL, 8'h10);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h90);
        writeReg(ADDR_STATUS_CONTROL, 8'h10);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h10);
        // Interrupt enabled only once the flag is clear, then a wrap raises it
        writeReg(ADDR_STATUS_CONTROL, 8'h40);
        pulses(2);
        #1 check({7'h00, irq}, 8'h01);
        writeReg(ADDR_STATUS_CONTROL, 8'h50);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'hd0);
        writeReg(ADDR_STATUS_CONTROL, 8'h50);
        #1 check({7'h00, irq}, 8'h00);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h50);
        // Counter clear, then modulo write, each drops a set flag
        for (int s = 0; s < 2; s++) begin
            writeReg(ADDR_STATUS_CONTROL, 8'h00);
            pulses(3);
            writeReg(ADDR_STATUS_CONTROL, 8'h10);
            if (s == 0) writeReg(ADDR_STATUS_CONTROL, 8'h30);
            else writeReg(ADDR_MODULO_VALUE, 8'h01);
            readReg(ADDR_STATUS_CONTROL, got);
            check(got, 8'h10);
            readReg(ADDR_COUNT_VALUE, got);
            check(got, 8'h00);
        end
        // Stop and debug freeze the count, which then resumes
        writeReg(ADDR_MODULO_VALUE, 8'h00);
        writeReg(ADDR_STATUS_CONTROL, 8'h20);
        stopMode <= 1'b1;
        pulses(4);
        @(posedge clk);
        stopMode <= 1'b0;
        debugActive <= 1'b1;
        pulses(4);
        @(posedge clk);
        debugActive <= 1'b0;
        pulses(3);
        writeReg(ADDR_STATUS_CONTROL, 8'h10);
        readReg(ADDR_COUNT_VALUE, got);
        check(got, 8'h03);
        // External pin, falling then rising edge, slow enough for the synchroniser
        for (int src = 2; src < 4; src++) begin
            writeReg(ADDR_CLOCK_CONFIG, {2'b00, src[1:0], 4'h0});
            writeReg(ADDR_MODULO_VALUE, 8'h00);
            writeReg(ADDR_STATUS_CONTROL, 8'h00);
            repeat (6) begin
                repeat (4) @(posedge clk);
                extClockIn <= ~extClockIn;
            end
            repeat (6) @(posedge clk);
            writeReg(ADDR_STATUS_CONTROL, 8'h10);
            readReg(ADDR_COUNT_VALUE, got);
            check(got, 8'h03);
        end
        // Bus clock with a modulo of 3 never passes the limit
        writeReg(ADDR_CLOCK_CONFIG, 8'h00);
        writeReg(ADDR_MODULO_VALUE, 8'h03);
        writeReg(ADDR_STATUS_CONTROL, 8'h00);
        repeat (20) @(posedge clk);
        writeReg(ADDR_STATUS_CONTROL, 8'h10);
        readReg(ADDR_COUNT_VALUE, got);
        check({7'h00, got <= 8'h03}, 8'h01);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h90);
        // Free run from zero: 302 bus ticks wrap once past the top
        writeReg(ADDR_MODULO_VALUE, 8'h00);
        writeReg(ADDR_STATUS_CONTROL, 8'h00);
        repeat (300) @(posedge clk);
        writeReg(ADDR_STATUS_CONTROL, 8'h10);
        readReg(ADDR_COUNT_VALUE, got);
        check(got, 8'h2e);
        readReg(ADDR_STATUS_CONTROL, got);
        check(got, 8'h90);
        // Deep stop wake restores every reset value
        writeReg(ADDR_CLOCK_CONFIG, 8'h37);
        writeReg(ADDR_MODULO_VALUE, 8'h44);
        writeReg(ADDR_STATUS_CONTROL, 8'h40);
        @(posedge clk);
        deepStopWake <= 1'b1;
        @(posedge clk);
        deepStopWake <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            readReg(a[1:0], got);
            check(got, (a == 0) ? 8'h10 : 8'h00);
        end
        giveVerdict();
    end
endmodule : tb
